// ==== inc/umx_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes avalon-mm word addressing, 32-bit data, one register per word
`ifndef UMX_MAP_SVH
`define UMX_MAP_SVH
// register word offsets (byte address = 4 * offset)
`define UMX_CTRL_OFS    3'h0
`define UMX_STAT_OFS    3'h1
`define UMX_TXD_OFS     3'h2
`define UMX_RXD_OFS     3'h3
`define UMX_BAUD_OFS    3'h4
// control field positions
`define UMX_C_TE        0
`define UMX_C_RE        1
`define UMX_C_TIE       2
`define UMX_C_TX_END_IRQ_ENABLE      3
`define UMX_C_RIE       4
`define UMX_C_MP_SKIP_ENABLE      5
`define UMX_C_MPF       6
`define UMX_C_PEN       7
`define UMX_C_SYNC      8
`define UMX_C_PDIR      9
`define UMX_C_PDAT      10
// status field positions
`define UMX_S_TX_EMPTY_FLAG      0
`define UMX_S_TX_END_FLAG      1
`define UMX_S_RX_FULL_FLAG      2
`define UMX_S_FER       3
`define UMX_S_OER       4
`define UMX_S_PER       5
`define UMX_S_RX_MP_BIT      6
`define UMX_S_TX_MP_BIT      7
// reset values
`define UMX_CTRL_RST    11'h000
`define UMX_BAUD_RST    16'h0001
// oversampling ratio and mid-bit sample point
`define UMX_OVS         5'h10
`define UMX_MID         4'h7
`endif

// ==== inc/umx_pkg.sv ====
// types shared by the multiprocessor serial unit
// assumes the map header for the field positions
package umx_pkg;
  // avalon-mm request from the master
  typedef struct packed {
    logic [2:0]  address;    // word offset
    logic        read;       // read strobe
    logic        write;      // write strobe
    logic [3:0]  byteenable; // byte lanes
    logic [31:0] writedata;  // write data
  } umx_avs_req_t;
  // four interrupt requests
  typedef struct packed {
    logic rx_full_irq;   // receive full
    logic tx_empty_irq;  // transmit empty
    logic tx_end_irq;    // transmission end
    logic rx_error_irq;  // receive error
  } umx_irq_t;
  // receiver and transmitter states
  typedef enum logic [1:0] {
    UMX_IDLE,
    UMX_START,
    UMX_BITS,
    UMX_STOP
  } umx_state_t;
endpackage

// ==== core/umx_uart.sv ====
// multiprocessor serial unit: tx, rx, flags, requests, avalon slave
// assumes rxd_pin is asynchronous; registers reached over avalon-mm
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "umx_map.svh"
module umx_uart (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire umx_pkg::umx_avs_req_t avs_req,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  output logic                    avs_readdatavalid,
  input  wire logic               rxd_pin,
  output logic                    txd_out,
  output logic                    txd_oe,
  output umx_pkg::umx_irq_t       irq
);
  import umx_pkg::*;

  // reset release through two flops
  logic rs1_q, rs2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire logic rst_i_n = rs2_q;

  // rx pin synchroniser
  logic rx1_q, rx2_q;
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rx1_q <= 1'b1;
      rx2_q <= 1'b1;
    end else if (clk_en) begin
      rx1_q <= rxd_pin;
      rx2_q <= rx1_q;
    end
  end

  // register file
  logic [10:0] ctrl_q, ctrl_d;     // serial_control_reg
  logic [15:0] baud_q, baud_d;     // basic clock divider
  logic [7:0]  tx_data_reg_q, tx_data_reg_d;
  logic [7:0]  rx_data_reg_q, rx_data_reg_d;
  logic tx_empty_flag_q, tx_empty_flag_d, tx_end_flag_q, tx_end_flag_d, rx_full_flag_q, rx_full_flag_d;
  logic fer_q, fer_d, oer_q, oer_d, per_q, per_d;
  logic rx_mp_bit_q, rx_mp_bit_d, tx_mp_bit_q, tx_mp_bit_d;
  // bus answer
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;       // answered cycle
  logic        rvalid_q, rvalid_d;

  // basic clock tick: 16 per bit
  logic [15:0] bdiv_q, bdiv_d;
  logic        tick;
  // transmitter
  umx_state_t  ts_q, ts_d;
  logic [3:0]  tsub_q, tsub_d;
  logic [3:0]  tbit_q, tbit_d;
  logic [9:0]  tsr_q, tsr_d;
  logic        txo_q, txo_d;
  logic        toe_q, toe_d;
  // receiver
  umx_state_t  rs_q, rs_d;
  logic [3:0]  rsub_q, rsub_d;
  logic [3:0]  rbit_q, rbit_d;
  logic [9:0]  rsr_q, rsr_d;        // rx_shift_reg
  logic        rxp_q, rxp_d;        // previous sampled level
  logic [9:0]  rx_frame;            // stop, flag and data aligned
  umx_irq_t    irq_q, irq_d;

  // bit count of a frame after start: 8 data + mp/parity
  function automatic logic [3:0] frame_bits(input logic extra);
    frame_bits = extra ? 4'h9 : 4'h8;
  endfunction
  function automatic logic parity8(input logic [7:0] v);
    parity8 = ^v;
  endfunction

  wire logic te   = ctrl_q[`UMX_C_TE];
  wire logic re   = ctrl_q[`UMX_C_RE];
  wire logic mpf  = ctrl_q[`UMX_C_MPF];
  wire logic pen  = ctrl_q[`UMX_C_PEN] & ~mpf;
  wire logic sync = ctrl_q[`UMX_C_SYNC];
  wire logic extra = mpf | pen;
  wire logic req  = (avs_req.read | avs_req.write) & ~ack_q;
  wire logic wr   = avs_req.write & ~ack_q;
  wire logic rd   = avs_req.read & ~ack_q;
  wire logic [2:0] ad = avs_req.address;
  wire logic [31:0] wd = avs_req.writedata;

  // receive and transmit events from the rx and tx state machines
  logic rx_done, rx_take, rx_fe, rx_pe, rx_mp;
  logic tx_load, tx_fin;

  // basic clock divider
  always_comb begin
    bdiv_d = bdiv_q + 16'h0001;
    tick   = 1'b0;
    if (bdiv_q >= baud_q - 16'h0001) begin
      bdiv_d = 16'h0000;
      tick   = 1'b1;
    end
  end

  // transmitter: start, data, flag bit, stop
  always_comb begin
    ts_d = ts_q; tsub_d = tsub_q; tbit_d = tbit_q;
    tsr_d = tsr_q; txo_d = txo_q; toe_d = 1'b1;
    tx_load = 1'b0; tx_fin = 1'b0;
    if (!te) begin
      ts_d = UMX_IDLE;
      tsub_d = 4'h0;
      txo_d = ctrl_q[`UMX_C_PDAT];
      toe_d = ctrl_q[`UMX_C_PDIR];
    end else begin
      case (ts_q)
        UMX_IDLE: begin
          txo_d = 1'b1;
          // sync mode: pending rx errors block the start
          if (!tx_empty_flag_q && !(sync && (oer_q | fer_q | per_q))) begin
            tx_load = 1'b1;
            tsr_d = {mpf ? tx_mp_bit_q
                     : parity8(tx_data_reg_q), tx_data_reg_q, 1'b0};
            ts_d = UMX_BITS; tsub_d = 4'h0; tbit_d = 4'h0;
            txo_d = 1'b0;
          end
        end
        UMX_BITS: if (tick) begin
          tsub_d = tsub_q + 4'h1;
          if (tsub_q == 4'hF) begin
            tsr_d = {1'b1, tsr_q[9:1]};
            txo_d = tsr_q[1];
            tbit_d = tbit_q + 4'h1;
            if (tbit_q == frame_bits(extra)) begin
              txo_d = 1'b1; ts_d = UMX_STOP;
            end
          end
        end
        UMX_STOP: if (tick) begin
          tsub_d = tsub_q + 4'h1;
          if (tsub_q == 4'hF) begin
            ts_d = UMX_IDLE; tx_fin = 1'b1;
          end
        end
        default: ts_d = UMX_IDLE;
      endcase
    end
  end

  // receiver: 16x oversample, mid-bit latch
  always_comb begin
    rs_d = rs_q; rsub_d = rsub_q; rbit_d = rbit_q;
    rsr_d = rsr_q; rxp_d = rxp_q;
    rx_done = 1'b0;
    if (tick) rxp_d = rx2_q;
    if (!re) begin
      rs_d = UMX_IDLE;
    end else if (tick) begin
      case (rs_q)
        UMX_IDLE:
          // halted while overrun or framing pending
          if (rxp_q && !rx2_q && !oer_q && !fer_q) begin
            rs_d = UMX_START; rsub_d = 4'h0;
          end
        UMX_START: begin
          rsub_d = rsub_q + 4'h1;
          if (rsub_q == `UMX_MID) begin
            if (rx2_q) rs_d = UMX_IDLE;
            else begin
              rs_d = UMX_BITS; rbit_d = 4'h0;
            end
          end
        end
        UMX_BITS: begin
          rsub_d = rsub_q + 4'h1;
          if (rsub_q == `UMX_MID) begin
            rsr_d = {rx2_q, rsr_q[9:1]};
            rbit_d = rbit_q + 4'h1;
            if (rbit_q == frame_bits(extra)) begin
              rx_done = 1'b1;                            // stop bit in msb
              rs_d = UMX_IDLE;
            end
          end
        end
        default: rs_d = UMX_IDLE;
      endcase
    end
  end

  // decode of a completed frame; without a flag bit the data sits one
  // place higher in the shifter, so realign it first
  always_comb begin
    rx_frame = extra ? rsr_d : {rsr_d[9], 1'b0, rsr_d[8:1]};
    rx_fe = ~rx_frame[9];
    rx_mp = mpf & rx_frame[8];
    rx_pe = pen & (parity8(rx_frame[7:0]) != rx_frame[8]);
    // skip data frames while skip is enabled
    rx_take = rx_done & ~(ctrl_q[`UMX_C_MP_SKIP_ENABLE] & ~rx_mp);
  end

  // registers, flags and bus answer
  always_comb begin
    ctrl_d = ctrl_q; baud_d = baud_q;
    tx_data_reg_d = tx_data_reg_q; rx_data_reg_d = rx_data_reg_q;
    tx_empty_flag_d = tx_empty_flag_q; tx_end_flag_d = tx_end_flag_q; rx_full_flag_d = rx_full_flag_q;
    fer_d = fer_q; oer_d = oer_q; per_d = per_q;
    rx_mp_bit_d = rx_mp_bit_q; tx_mp_bit_d = tx_mp_bit_q;
    rdata_d = 32'h0000_0000; ack_d = req; rvalid_d = rd;
    // software writes first, hardware sets override
    if (wr && avs_req.byteenable[0]) begin
      if (ad == `UMX_CTRL_OFS) begin
        ctrl_d = wd[10:0];
      end else if (ad == `UMX_STAT_OFS) begin
        // error and end flags clear by writing zero; rx enable clear keeps them
        if (!wd[`UMX_S_FER]) fer_d = 1'b0;
        if (!wd[`UMX_S_OER]) oer_d = 1'b0;
        if (!wd[`UMX_S_PER]) per_d = 1'b0;
        if (!wd[`UMX_S_TX_END_FLAG]) tx_end_flag_d = 1'b0;
        tx_mp_bit_d = wd[`UMX_S_TX_MP_BIT];
      end else if (ad == `UMX_TXD_OFS) begin
        tx_data_reg_d = wd[7:0];
        tx_empty_flag_d = 1'b0;
        tx_end_flag_d = 1'b0;
      end else if (ad == `UMX_BAUD_OFS) begin
        baud_d = (wd[15:0] == 16'h0000) ? 16'h0001 : wd[15:0];
      end
    end
    if (rd) begin
      if (ad == `UMX_CTRL_OFS) begin
        rdata_d = {21'h000000, ctrl_q};
      end else if (ad == `UMX_STAT_OFS) begin
        rdata_d = {24'h000000, tx_mp_bit_q, rx_mp_bit_q, per_q, oer_q,
                   fer_q, rx_full_flag_q, tx_end_flag_q, tx_empty_flag_q};
      end else if (ad == `UMX_TXD_OFS) begin
        rdata_d = {24'h000000, tx_data_reg_q};
      end else if (ad == `UMX_RXD_OFS) begin
        rdata_d = {24'h000000, rx_data_reg_q};
        rx_full_flag_d = 1'b0;
      end else if (ad == `UMX_BAUD_OFS) begin
        rdata_d = {16'h0000, baud_q};
      end
    end
    if (tx_load) tx_empty_flag_d = 1'b1;
    if (tx_fin && tx_empty_flag_q) tx_end_flag_d = 1'b1;
    if (rx_take) begin
      rx_mp_bit_d = rx_mp;
      if (ctrl_q[`UMX_C_MP_SKIP_ENABLE] && rx_mp) begin
        rx_mp_bit_d = 1'b1;
        ctrl_d[`UMX_C_MP_SKIP_ENABLE] = 1'b0;
      end
      if (rx_full_flag_q) oer_d = 1'b1;
      else begin
        rx_data_reg_d = rx_frame[7:0];
        rx_full_flag_d = 1'b1;
      end
      if (rx_fe) fer_d = 1'b1;
      if (rx_pe) per_d = 1'b1;
    end
    // requests follow flags and enables
    irq_d.rx_full_irq  = rx_full_flag_d & ctrl_d[`UMX_C_RIE];
    irq_d.tx_empty_irq = tx_empty_flag_d & ctrl_d[`UMX_C_TIE];
    irq_d.tx_end_irq   = tx_end_flag_d & ctrl_d[`UMX_C_TX_END_IRQ_ENABLE];
    irq_d.rx_error_irq = (oer_d | fer_d | per_d)
                         & ctrl_d[`UMX_C_RIE];
  end

  // state registers
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ctrl_q <= `UMX_CTRL_RST; baud_q <= `UMX_BAUD_RST;
      tx_data_reg_q <= 8'h00; rx_data_reg_q <= 8'h00;
      tx_empty_flag_q <= 1'b1;
      tx_end_flag_q <= 1'b1;
      rx_full_flag_q <= 1'b0; fer_q <= 1'b0; oer_q <= 1'b0;
      per_q <= 1'b0; rx_mp_bit_q <= 1'b0; tx_mp_bit_q <= 1'b0;
      rdata_q <= 32'h0000_0000; ack_q <= 1'b0; rvalid_q <= 1'b0;
      bdiv_q <= 16'h0000;
      ts_q <= UMX_IDLE; tsub_q <= 4'h0; tbit_q <= 4'h0;
      tsr_q <= 10'h3FF; txo_q <= 1'b1; toe_q <= 1'b0;
      rs_q <= UMX_IDLE; rsub_q <= 4'h0; rbit_q <= 4'h0;
      rsr_q <= 10'h000; rxp_q <= 1'b1;
      irq_q <= '0;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d; baud_q <= baud_d;
      tx_data_reg_q <= tx_data_reg_d; rx_data_reg_q <= rx_data_reg_d;
      tx_empty_flag_q <= tx_empty_flag_d; tx_end_flag_q <= tx_end_flag_d; rx_full_flag_q <= rx_full_flag_d;
      fer_q <= fer_d; oer_q <= oer_d; per_q <= per_d;
      rx_mp_bit_q <= rx_mp_bit_d; tx_mp_bit_q <= tx_mp_bit_d;
      rdata_q <= rdata_d; ack_q <= ack_d; rvalid_q <= rvalid_d;
      bdiv_q <= bdiv_d;
      ts_q <= ts_d; tsub_q <= tsub_d; tbit_q <= tbit_d;
      tsr_q <= tsr_d; txo_q <= txo_d; toe_q <= toe_d;
      rs_q <= rs_d; rsub_q <= rsub_d; rbit_q <= rbit_d;
      rsr_q <= rsr_d; rxp_q <= rxp_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = ~ack_q;
  assign avs_readdatavalid = rvalid_q;
  assign txd_out = txo_q;
  assign txd_oe  = toe_q;
  assign irq     = irq_q;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_i_n);

  a_skip_blocks_rx_full_flag: assert property (
    (rx_done && ctrl_q[`UMX_C_MP_SKIP_ENABLE] && !rx_mp && clk_en && !rd)
    |=> rx_full_flag_q == $past(rx_full_flag_q))
    else $error("skipped frame changed rx full");
  a_id_clears_skip: assert property (
    (rx_done && ctrl_q[`UMX_C_MP_SKIP_ENABLE] && rx_mp && clk_en && !wr)
    |=> !ctrl_q[`UMX_C_MP_SKIP_ENABLE] && rx_mp_bit_q)
    else $error("id frame did not end skipping");
  a_txe_irq_reset: assert property (
    (tx_empty_flag_q && ctrl_q[`UMX_C_TIE] && clk_en && !wr) |=> irq.tx_empty_irq)
    else $error("tx empty request missing");
  a_tx_end_flag_irq_reset: assert property (
    (tx_end_flag_q && ctrl_q[`UMX_C_TX_END_IRQ_ENABLE] && clk_en && !wr) |=> irq.tx_end_irq)
    else $error("tx end request missing");
  a_port_pin_mode: assert property (
    (!te && clk_en) |=> txd_out == $past(ctrl_q[`UMX_C_PDAT])
    && txd_oe == $past(ctrl_q[`UMX_C_PDIR]))
    else $error("pin not following port bits");
  a_te_reset_tx: assert property (
    (!te && clk_en) |=> ts_q == UMX_IDLE)
    else $error("transmitter not reset");
  a_sync_err_block: assert property (
    (sync && (oer_q || fer_q || per_q) && ts_q == UMX_IDLE && clk_en)
    |=> ts_q == UMX_IDLE)
    else $error("tx started with rx error");
  a_re_keeps_err: assert property (
    (fer_q && !(wr && ad == `UMX_STAT_OFS)) |=> fer_q)
    else $error("framing flag lost");
  a_read_clears_rx_full_flag: assert property (
    (rd && ad == `UMX_RXD_OFS && clk_en && !rx_take) |=> !rx_full_flag_q)
    else $error("rx full not cleared by read");
  a_rx_halt_err: assert property (
    ((oer_q || fer_q) && rs_q == UMX_IDLE && clk_en) |=> rs_q == UMX_IDLE)
    else $error("reception resumed with error");
  c_id_frame: cover property (rx_done && rx_mp);
  c_overrun: cover property (rx_take && rx_full_flag_q);
  c_tx_end: cover property (tx_fin);
  c_break: cover property (rx_done && rx_fe);
  c_skip_frame: cover property (rx_done && ctrl_q[`UMX_C_MP_SKIP_ENABLE] && !rx_mp);
  a_mp_bit_track: assert property (
    (rx_take && !rx_mp && clk_en) |=> !rx_mp_bit_q)
    else $error("rx mp bit not updated");
  a_mp_no_parity: assert property (
    (rx_take && mpf && !per_q && clk_en && !wr) |=> !per_q)
    else $error("parity checked in mp format");
  a_break_fer: assert property (
    (rx_take && rx_fe && clk_en) |=> fer_q)
    else $error("framing flag not set on break");
  a_rx_full_irq: assert property (
    (rx_take && !rx_full_flag_q && ctrl_q[`UMX_C_RIE] && clk_en && !wr)
    |=> irq.rx_full_irq && rx_full_flag_q)
    else $error("rx full request missing");
  a_tx_owns_pin: assert property (
    (te && clk_en) |=> txd_oe)
    else $error("transmitter not driving pin");
endmodule

// ==== tb/umx_peer.sv ====
// far-side station on the shared serial line: sends and receives frames
// assumes baud divider 1, so one 16x tick per clk and 16 clk per bit
`timescale 1ns/1ns
module umx_peer (
  input  wire logic clk,
  output logic      line_out,
  input  wire logic txd,
  input  wire logic txd_oe
);
  localparam int BIT_CYC = 16; // clk cycles per bit
  logic line_in; // wire level at the design transmit pin
  // released pin floats to mark through the line pull-up
  assign line_in = txd_oe ? txd : 1'b1;
  // idle line is mark
  initial line_out = 1'b1;
  // start, 8 data lsb first, optional flag bit, stop
  task automatic send(input logic [7:0] d, input logic has_flag,
                      input logic flag, input logic stop);
    int          i;
    int          n;
    logic [10:0] bits;
    n = has_flag ? 11 : 10;
    bits = has_flag ? {stop, flag, d, 1'b0} : {1'b0, stop, d, 1'b0};
    @(posedge clk);
    for (i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
  // wait for a start edge, then sample each bit near mid-bit
  task automatic recv(input logic has_flag, output logic [9:0] got,
                      output logic ok);
    int i;
    int n;
    n = 0;
    got = '0;
    while (line_in !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 2000);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (i = 0; i < (has_flag ? 10 : 9); i++) begin
      repeat (BIT_CYC) @(posedge clk);
      got[i] = line_in;
    end
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the multiprocessor serial unit
// assumes the peer model on the serial pins and baud divider at reset (1)
`timescale 1ns/1ns
`include "umx_map.svh"
module tb;
  import umx_pkg::*;
  // control word bits
  localparam logic [31:0] EN_TX = 32'h001, EN_RX = 32'h002;
  localparam logic [31:0] IE_TXE = 32'h004, IE_END = 32'h008;
  localparam logic [31:0] IE_RX = 32'h010, MP_SKIP = 32'h020;
  localparam logic [31:0] MP_FMT = 32'h040, PAR_EN = 32'h080;
  localparam logic [31:0] SYNC_MD = 32'h100, P_DIR = 32'h200;
  localparam logic [31:0] P_DAT = 32'h400;
  logic         clk, rst_n, clk_en, rxd, txd, txd_oe, wreq, rvalid;
  logic  [31:0] rdata;
  umx_avs_req_t req;
  umx_irq_t     irq;
  int           error_cnt, num_checks;
  // 250 mhz clock
  always #2 clk = ~clk;
  umx_uart i_umx_uart (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .avs_readdatavalid(rvalid), .rxd_pin(rxd), .txd_out(txd),
    .txd_oe(txd_oe), .irq(irq));
  umx_peer i_umx_peer (.clk(clk), .line_out(rxd), .txd(txd),
    .txd_oe(txd_oe));
  // closing report
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic [2:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rv);
    int n;
    n = 0;
    @(posedge clk);
    req.address <= a;
    req.byteenable <= 4'hF;
    req.writedata <= wd;
    req.write <= w;
    req.read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rv = rdata;
    chk(rvalid === ~w, "read data valid flag");
    req.write <= 1'b0;
    req.read <= 1'b0;
    if (n >= 50) begin
      chk(1'b0, "bus timeout");
      print_verdict();
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] v);
    xfer(a, 1'b0, 32'h0, v);
  endtask
  // let cycles pass and settle past the edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // count low cycles on the transmit pin over a window
  task automatic lows(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (txd !== 1'b1) c++;
    end
  endtask
  task automatic s_reset();
    logic [31:0] v;
    rd(`UMX_STAT_OFS, v);
    chk(v[2:0] === 3'b011, "flags after reset");
    rd(3'h5, v);
    chk(v === 32'h0, "unmapped read");
    wr(`UMX_CTRL_OFS, IE_TXE | IE_END);
    wait_cyc(2);
    chk(irq.tx_empty_irq === 1'b1, "early empty request");
    chk(irq.tx_end_irq === 1'b1, "early end request");
  endtask
  task automatic s_tx_mp();
    logic [9:0] got;
    logic       ok;
    wr(`UMX_CTRL_OFS, MP_FMT);
    wr(`UMX_STAT_OFS, 32'hBA);
    wr(`UMX_TXD_OFS, 32'h5A);
    wr(`UMX_CTRL_OFS, MP_FMT | IE_TXE | IE_END);
    wait_cyc(2);
    chk(irq[2:1] === 2'b00, "no early tx requests");
    fork
      i_umx_peer.recv(1'b1, got, ok);
      wr(`UMX_CTRL_OFS, EN_TX | MP_FMT | IE_TXE | IE_END);
    join
    chk(ok && got === 10'h35A, "id frame on line");
    wait_cyc(12);
    chk(irq.tx_end_irq === 1'b1, "end request after frame");
    wr(`UMX_STAT_OFS, 32'h3A);
    fork
      i_umx_peer.recv(1'b1, got, ok);
      wr(`UMX_TXD_OFS, 32'hC3);
    join
    chk(ok && got === 10'h2C3, "data frame on line");
  endtask
  task automatic s_rx_skip();
    logic [31:0] v;
    wr(`UMX_CTRL_OFS, EN_RX | MP_FMT | PAR_EN | MP_SKIP | IE_RX);
    i_umx_peer.send(8'h11, 1'b1, 1'b0, 1'b1);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[2] === 1'b0 && irq.rx_full_irq === 1'b0, "skipped");
    i_umx_peer.send(8'h42, 1'b1, 1'b1, 1'b1);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[6:2] === 5'b10001, "id accepted, no parity");
    chk(irq.rx_full_irq === 1'b1, "rx full request");
    rd(`UMX_CTRL_OFS, v);
    chk(v[5] === 1'b0, "skip cleared");
    rd(`UMX_RXD_OFS, v);
    chk(v === 32'h42, "id char");
    rd(`UMX_STAT_OFS, v);
    chk(v[2] === 1'b0, "read clears full");
    i_umx_peer.send(8'h99, 1'b1, 1'b0, 1'b1);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[2] === 1'b1 && v[6] === 1'b0, "data after id");
    rd(`UMX_RXD_OFS, v);
    chk(v === 32'h99, "data char");
    i_umx_peer.send(8'h17, 1'b1, 1'b1, 1'b1);
    wait_cyc(4);
    rd(`UMX_RXD_OFS, v);
    chk(v === 32'h17, "foreign id char");
    // id is not ours: re-arm skipping for the data behind it
    wr(`UMX_CTRL_OFS, EN_RX | MP_FMT | MP_SKIP | IE_RX);
    i_umx_peer.send(8'h66, 1'b1, 1'b0, 1'b1);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[2] === 1'b0, "foreign data skipped");
  endtask
  task automatic s_break();
    logic [31:0] v;
    wr(`UMX_CTRL_OFS, EN_RX | IE_RX);
    i_umx_peer.send(8'h00, 1'b0, 1'b0, 1'b0);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[3] === 1'b1 && irq.rx_error_irq === 1'b1, "break");
    rd(`UMX_RXD_OFS, v);
    wr(`UMX_STAT_OFS, 32'hF7);
    i_umx_peer.send(8'h00, 1'b0, 1'b0, 1'b0);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[3] === 1'b1, "framing sets again");
    rd(`UMX_RXD_OFS, v);
    i_umx_peer.send(8'h55, 1'b0, 1'b0, 1'b1);
    wait_cyc(4);
    rd(`UMX_STAT_OFS, v);
    chk(v[2] === 1'b0, "halted on framing");
    wr(`UMX_CTRL_OFS, 32'h0);
    rd(`UMX_STAT_OFS, v);
    chk(v[3] === 1'b1, "rx off keeps framing");
  endtask
  task automatic s_sync();
    logic [9:0] got;
    logic       ok;
    int         c;
    wr(`UMX_CTRL_OFS, EN_TX | SYNC_MD);
    wr(`UMX_TXD_OFS, 32'h3C);
    lows(200, c);
    chk(c == 0, "no start on error");
    fork
      i_umx_peer.recv(1'b0, got, ok);
      wr(`UMX_STAT_OFS, 32'hC7);
    join
    chk(ok && got[8:0] === 9'h13C, "start after clear");
  endtask
  task automatic s_port();
    int c;
    wr(`UMX_CTRL_OFS, EN_TX | P_DIR | P_DAT);
    wr(`UMX_TXD_OFS, 32'hFF);
    wait_cyc(40);
    wr(`UMX_CTRL_OFS, EN_TX | P_DIR);
    wr(`UMX_CTRL_OFS, P_DIR);
    wait_cyc(2);
    chk(txd_oe === 1'b1 && txd === 1'b0, "break on pin");
    wr(`UMX_CTRL_OFS, P_DIR | P_DAT);
    wait_cyc(2);
    chk(txd_oe === 1'b1 && txd === 1'b1, "mark on pin");
    wr(`UMX_CTRL_OFS, 32'h0);
    wait_cyc(2);
    chk(txd_oe === 1'b0, "pin released");
    wr(`UMX_CTRL_OFS, EN_TX);
    lows(200, c);
    chk(c == 0, "aborted frame not resumed");
  endtask
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    req = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_reset();
    s_tx_mp();
    s_rx_skip();
    s_break();
    s_sync();
    s_port();
    print_verdict();
  end
endmodule
